//--- rtl/adsc_dev.sv
// Converter end: power-on and on-command self-calibration sequencing.
// Behaviour
// R1 - Calibrate after power-up and on valid request.
// R2 - Same calibration whether clock early or late.
// R3 - Busy flag high exactly while calibrating.
// R4 - Power-on calibration waits selected start-up delay.
// R5 - Wait select picks one of two delays.
// R6 - Power down high freezes delay counter.
// R7 - Extended mode always uses the short delay.
// R8 - Request pin high at power-up skips calibration.
// R9 - Analog held down until clock starts.
// R10 - Controller calibrates only outside dual-edge mode.
// R11 - Request needs 80 low then 80 high.
// R12 - Calibration begins 80 cycles after rising.
// R13 - Outputs and data clock off while busy.
// R14 - Outputs return after busy, settle 100 ns.
// R15 - Data clock is not a system clock.
// R16 - Controller recalibrates after 20 s, temperature change; the code only sets the advise status bit after 20 s and ignores temperature.
// R17 - Span select picks 650 or 870 mV.
// R18 - Power down waits for running calibration.
// R19 - Requests ignored while powered down.
// R20 - Start-up delays are parameterised cycle counts.
`timescale 1ns/1ns
`default_nettype none
`include "adsc_consts.svh"
module adsc_dev #(
	parameter int unsigned SHORT_WAIT_CYC = `ADSC_SHORT_WAIT,
	parameter int unsigned LONG_WAIT_CYC  = `ADSC_LONG_WAIT,
	parameter int unsigned CAL_CYC        = `ADSC_CAL_CYC
) (
	input  wire logic              CLK_SYS,
	input  wire logic              RST_B,
	input  wire logic              CE,
	input  wire adsc_pkg::adsc_data_t CONV_DATA,
	adsc_if.dev                    LINK,
	output logic                   ANALOG_PD,
	output logic                   OUT_READY
);
	import adsc_pkg::*;

	localparam logic [2:0] SETTLE_CYC = 3'(`ADSC_SETTLE_CYC);

	adsc_dev_st_t st_r;
	adsc_dev_st_t st_nxt;
	logic         first_r;
	logic         skip_r;
	logic [31:0]  wait_cnt_r;
	logic [31:0]  wait_target;
	logic [31:0]  cal_cnt_r;
	logic [6:0]   lo_cnt_r;
	logic [6:0]   hi_cnt_r;
	logic         armed_r;
	logic         req_fire;
	logic         filter_on;
	logic         busy;
	logic         analog_pd_r;
	adsc_data_t   data_r;
	logic         output_data_clock_r;
	logic [2:0]   settle_cnt_r;
	adsc_mv_t     span_r;

	assign busy = (st_r == DEV_CAL);

	// The request pin is caught as a strap on the first clock edge after reset release.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			first_r <= 1'b1;
			skip_r  <= 1'b0;
		end
		else if (CE && first_r)
		begin
			first_r <= 1'b0;
			skip_r  <= LINK.trim_req; // R8
		end
	end

	// Extended mode forces the short delay, otherwise the select pin decides.
	always_comb
	begin
		if (LINK.ext_mode || !LINK.startup_wait_select) // R7
			wait_target = SHORT_WAIT_CYC - 32'd1; // R20
		else
			wait_target = LONG_WAIT_CYC - 32'd1; // R5
	end

	// The delay count only needs clock edges, so a late clock just starts it later.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			wait_cnt_r <= 32'h0000_0000;
		else if (CE && st_r == DEV_BOOT && !LINK.power_down_pin && wait_cnt_r < wait_target) // R6 R2
			wait_cnt_r <= wait_cnt_r + 32'd1;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			cal_cnt_r <= 32'h0000_0000;
		else if (CE)
		begin
			if (busy)
				cal_cnt_r <= cal_cnt_r + 32'd1;
			else
				cal_cnt_r <= 32'h0000_0000;
		end
	end

	// Noise filter on the request pin; cleared while powered down or calibrating.
	assign filter_on = (st_r == DEV_IDLE) || (st_r == DEV_BOOT);
	assign req_fire  = filter_on && armed_r && LINK.trim_req && (hi_cnt_r == `ADSC_REQ_CYC - 7'd1); // R11 R12

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			lo_cnt_r <= 7'h00;
			hi_cnt_r <= 7'h00;
			armed_r  <= 1'b0;
		end
		else if (CE)
		begin
			if (!filter_on || LINK.power_down_pin) // R19
			begin
				lo_cnt_r <= 7'h00;
				hi_cnt_r <= 7'h00;
				armed_r  <= 1'b0;
			end
			else if (!LINK.trim_req)
			begin
				hi_cnt_r <= 7'h00;
				if (lo_cnt_r == `ADSC_REQ_CYC - 7'd1)
					armed_r <= 1'b1; // R11
				else
					lo_cnt_r <= lo_cnt_r + 7'd1;
			end
			else
			begin
				lo_cnt_r <= 7'h00;
				if (req_fire)
				begin
					armed_r  <= 1'b0;
					hi_cnt_r <= 7'h00;
				end
				else if (armed_r)
					hi_cnt_r <= hi_cnt_r + 7'd1;
			end
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			DEV_BOOT:
			begin
				// A later switch to the shorter delay must not let the count run past its end.
				if (wait_cnt_r >= wait_target && !LINK.power_down_pin) // R4
					st_nxt = skip_r ? DEV_IDLE : DEV_CAL; // R1 R8
			end
			DEV_IDLE:
			begin
				if (LINK.power_down_pin)
					st_nxt = DEV_PDN;
				else if (req_fire)
					st_nxt = DEV_CAL; // R1 R12
			end
			DEV_CAL:
			begin
				// Power down is only looked at after returning to idle.
				if (cal_cnt_r == CAL_CYC - 32'd1) // R18
					st_nxt = DEV_IDLE;
			end
			DEV_PDN:
			begin
				if (!LINK.power_down_pin)
					st_nxt = DEV_IDLE;
			end
			default:
				st_nxt = DEV_BOOT;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			st_r <= DEV_BOOT;
		else if (CE)
			st_r <= st_nxt;
	end

	// Analog stays down from reset until a clock edge arrives, then follows power down except during a running calibration.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			analog_pd_r <= 1'b1; // R9
		else if (CE)
			analog_pd_r <= (st_nxt == DEV_PDN) || (st_nxt == DEV_BOOT && LINK.power_down_pin); // R18 R6
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			data_r <= 8'h00;
		else if (CE)
			data_r <= CONV_DATA;
	end

	// The data clock halts while calibrating, so receivers must not run from it.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			output_data_clock_r <= 1'b0;
		else if (CE && !busy && !analog_pd_r) // R13 R15
			output_data_clock_r <= ~output_data_clock_r;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			settle_cnt_r <= 3'h0;
		else if (CE)
		begin
			if (busy || analog_pd_r)
				settle_cnt_r <= 3'h0;
			else if (settle_cnt_r != SETTLE_CYC) // R14
				settle_cnt_r <= settle_cnt_r + 3'd1;
		end
	end

	// Extended range is clamped so a bad setting cannot leave the allowed span.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			span_r <= `ADSC_SPAN_LOW_MV;
		else if (CE)
		begin
			if (!LINK.ext_mode)
				span_r <= LINK.input_span_select ? `ADSC_SPAN_HIGH_MV : `ADSC_SPAN_LOW_MV; // R17
			else if (LINK.ext_span_mv < `ADSC_SPAN_MIN_MV)
				span_r <= `ADSC_SPAN_MIN_MV;
			else if (LINK.ext_span_mv > `ADSC_SPAN_MAX_MV)
				span_r <= `ADSC_SPAN_MAX_MV;
			else
				span_r <= LINK.ext_span_mv;
		end
	end

	assign LINK.trim_busy_flag    = busy; // R3
	assign LINK.data_out          = data_r;
	assign LINK.data_oe_n         = busy || analog_pd_r; // R13
	assign LINK.output_data_clock = output_data_clock_r;
	assign LINK.output_data_clock_oe_n         = busy || analog_pd_r; // R13
	assign LINK.span_mv           = span_r;
	assign ANALOG_PD              = analog_pd_r;
	assign OUT_READY              = (settle_cnt_r == SETTLE_CYC); // R14
endmodule : adsc_dev
`default_nettype wire

//--- rtl/adsc_consts.svh
// Named constants shared by the calibration control ends.
`ifndef ADSC_CONSTS_SVH
`define ADSC_CONSTS_SVH

`define ADSC_REQ_CYC       7'd80
`define ADSC_CLK_NS        20
`define ADSC_SETTLE_NS     100
`define ADSC_SETTLE_CYC    ((`ADSC_SETTLE_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)
`define ADSC_ADVISE_S      20
`define ADSC_ADVISE_CYC    (`ADSC_ADVISE_S * (1000000000 / `ADSC_CLK_NS))
`define ADSC_SHORT_WAIT    4096
`define ADSC_LONG_WAIT     65536
`define ADSC_CAL_CYC       8192

`define ADSC_SPAN_LOW_MV   10'd650
`define ADSC_SPAN_HIGH_MV  10'd870
`define ADSC_SPAN_MIN_MV   10'd560
`define ADSC_SPAN_MAX_MV   10'd840

`define ADSC_ADDR_CTRL     4'h0
`define ADSC_ADDR_CMD      4'h1
`define ADSC_ADDR_SPAN     4'h2
`define ADSC_ADDR_STAT     4'h3

`define ADSC_CTRL_PD       0
`define ADSC_CTRL_WAIT     1
`define ADSC_CTRL_SPAN     2
`define ADSC_CTRL_EXT      3
`define ADSC_CTRL_DES      4
`define ADSC_CTRL_RST      5'h00
`define ADSC_CMD_CAL       0
`define ADSC_STAT_SEQ      0
`define ADSC_STAT_BUSY     1
`define ADSC_STAT_DONE     2
`define ADSC_STAT_ADVISE   3
`define ADSC_STAT_REFUSED  4

`endif

//--- rtl/adsc_pkg.sv
// Types shared by the calibration control ends.
package adsc_pkg;
	typedef logic [7:0] adsc_data_t;
	typedef logic [9:0] adsc_mv_t;
	typedef logic [3:0] adsc_addr_t;
	typedef logic [15:0] adsc_word_t;
	typedef enum logic [1:0] {DEV_BOOT, DEV_IDLE, DEV_CAL, DEV_PDN} adsc_dev_st_t;
	typedef enum logic [2:0] {HST_IDLE, HST_EXIT_DES, HST_LOW, HST_HIGH, HST_WAIT_END} adsc_hst_st_t;
endpackage : adsc_pkg

//--- rtl/adsc_if.sv
// Control pins between the converter calibration logic and its controller.
`timescale 1ns/1ns
`default_nettype none
interface adsc_if;
	logic               trim_req;
	logic               power_down_pin;
	logic               startup_wait_select;
	logic               input_span_select;
	logic               ext_mode;
	logic               des_mode;
	adsc_pkg::adsc_mv_t ext_span_mv;
	logic               trim_busy_flag;
	adsc_pkg::adsc_data_t data_out;
	logic               data_oe_n;
	logic               output_data_clock;
	logic               output_data_clock_oe_n;
	adsc_pkg::adsc_mv_t span_mv;

	modport dev (
		input  trim_req, power_down_pin, startup_wait_select, input_span_select, ext_mode, des_mode, ext_span_mv,
		output trim_busy_flag, data_out, data_oe_n, output_data_clock, output_data_clock_oe_n, span_mv
	);
	modport host (
		output trim_req, power_down_pin, startup_wait_select, input_span_select, ext_mode, des_mode, ext_span_mv,
		input  trim_busy_flag, data_out, data_oe_n, output_data_clock, output_data_clock_oe_n, span_mv
	);
endinterface : adsc_if
`default_nettype wire

//--- rtl/adsc_host.sv
// Controller end: drives the converter control pins from a small register port.
`timescale 1ns/1ns
`default_nettype none
`include "adsc_consts.svh"
module adsc_host #(
	parameter int unsigned ADVISE_CYC = `ADSC_ADVISE_CYC
) (
	input  wire logic               CLK_SYS,
	input  wire logic               RST_B,
	input  wire logic               CE,
	input  wire adsc_pkg::adsc_addr_t ADDR,
	input  wire adsc_pkg::adsc_word_t WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output adsc_pkg::adsc_word_t    RDATA,
	adsc_if.host                    LINK
);
	import adsc_pkg::*;

	adsc_hst_st_t st_r;
	logic [4:0]   ctrl_r;
	adsc_mv_t     span_r;
	logic [6:0]   cnt_r;
	logic         done_r;
	logic         refused_r;
	logic [31:0]  adv_cnt_r;
	logic         advise_r;
	adsc_word_t   rdata_r;
	logic         cal_cmd;
	logic         start;
	logic [15:0]  stat;

	assign cal_cmd = WR && (ADDR == `ADSC_ADDR_CMD) && WDATA[`ADSC_CMD_CAL];
	// A request while powered down would be ignored by the converter, so refuse it here.
	assign start   = cal_cmd && (st_r == HST_IDLE) && !ctrl_r[`ADSC_CTRL_PD]; // R19

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ctrl_r <= `ADSC_CTRL_RST;
			span_r <= `ADSC_SPAN_LOW_MV;
		end
		else if (CE && WR)
		begin
			if (ADDR == `ADSC_ADDR_CTRL)
				ctrl_r <= WDATA[4:0];
			if (ADDR == `ADSC_ADDR_SPAN)
				span_r <= WDATA[9:0];
		end
	end

	// Leave dual-edge mode, pulse the pin low then high, wait for busy to end.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			st_r  <= HST_IDLE;
			cnt_r <= 7'h00;
		end
		else if (CE)
		begin
			case (st_r)
				HST_IDLE:
				begin
					cnt_r <= 7'h00;
					if (start)
						st_r <= HST_EXIT_DES; // R10
				end
				HST_EXIT_DES:
					st_r <= HST_LOW;
				HST_LOW:
				begin
					if (cnt_r == `ADSC_REQ_CYC - 7'd1) // R11
					begin
						cnt_r <= 7'h00;
						st_r  <= HST_HIGH;
					end
					else
						cnt_r <= cnt_r + 7'd1;
				end
				HST_HIGH:
				begin
					if (LINK.trim_busy_flag)
						st_r <= HST_WAIT_END;
				end
				HST_WAIT_END:
				begin
					if (!LINK.trim_busy_flag)
						st_r <= HST_IDLE;
				end
				default:
					st_r <= HST_IDLE;
			endcase
		end
	end

	// Sticky flags: a new event wins over a clearing write in the same cycle.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			done_r    <= 1'b0;
			refused_r <= 1'b0;
		end
		else if (CE)
		begin
			if (st_r == HST_WAIT_END && !LINK.trim_busy_flag)
				done_r <= 1'b1;
			else if (WR && ADDR == `ADSC_ADDR_STAT && WDATA[`ADSC_STAT_DONE])
				done_r <= 1'b0;
			if (cal_cmd && !start)
				refused_r <= 1'b1;
			else if (WR && ADDR == `ADSC_ADDR_STAT && WDATA[`ADSC_STAT_REFUSED])
				refused_r <= 1'b0;
		end
	end

	// Tells software when a recalibration gives best results after power-up.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			adv_cnt_r <= 32'h0000_0000;
			advise_r  <= 1'b0;
		end
		else if (CE && !advise_r)
		begin
			if (adv_cnt_r == ADVISE_CYC - 32'd1) // R16
				advise_r <= 1'b1;
			else
				adv_cnt_r <= adv_cnt_r + 32'd1;
		end
	end

	always_comb
	begin
		stat = 16'h0000;
		stat[`ADSC_STAT_SEQ]     = (st_r != HST_IDLE);
		stat[`ADSC_STAT_BUSY]    = LINK.trim_busy_flag;
		stat[`ADSC_STAT_DONE]    = done_r;
		stat[`ADSC_STAT_ADVISE]  = advise_r;
		stat[`ADSC_STAT_REFUSED] = refused_r;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			rdata_r <= 16'h0000;
		else if (CE)
		begin
			if (!RD)
				rdata_r <= 16'h0000;
			else if (ADDR == `ADSC_ADDR_CTRL)
				rdata_r <= {11'h000, ctrl_r};
			else if (ADDR == `ADSC_ADDR_SPAN)
				rdata_r <= {6'h00, span_r};
			else if (ADDR == `ADSC_ADDR_STAT)
				rdata_r <= stat;
			else
				rdata_r <= 16'h0000;
		end
	end

	// The data clock is never used as a clock here; only the busy flag is watched.
	assign RDATA                    = rdata_r; // R15
	assign LINK.trim_req            = (st_r == HST_HIGH); // R11
	assign LINK.power_down_pin      = ctrl_r[`ADSC_CTRL_PD];
	assign LINK.startup_wait_select = ctrl_r[`ADSC_CTRL_WAIT];
	assign LINK.input_span_select   = ctrl_r[`ADSC_CTRL_SPAN];
	assign LINK.ext_mode            = ctrl_r[`ADSC_CTRL_EXT];
	assign LINK.des_mode            = ctrl_r[`ADSC_CTRL_DES] && (st_r == HST_IDLE); // R10
	assign LINK.ext_span_mv         = span_r;
endmodule : adsc_host
`default_nettype wire

//--- bench/adsc_cal_monitor.sv
// Concurrent checks on the calibration control pins between the two ends.
`timescale 1ns/1ns
`default_nettype none
`include "adsc_consts.svh"
module adsc_cal_monitor #(
	parameter int unsigned CAL_CYC = 10
) (
	input wire logic                CLK_SYS,
	input wire logic                RST_B,
	input wire logic                trim_req,
	input wire logic                power_down_pin,
	input wire logic                input_span_select,
	input wire logic                ext_mode,
	input wire logic                des_mode,
	input wire logic                trim_busy_flag,
	input wire logic                data_oe_n,
	input wire logic                output_data_clock,
	input wire logic                output_data_clock_oe_n,
	input wire adsc_pkg::adsc_mv_t  span_mv
);
	import adsc_pkg::*;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	int unsigned busy_r;
	int unsigned low_r;
	// Both counters saturate or clear so they never wrap in long runs.
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			busy_r <= 0;
		else
			busy_r <= trim_busy_flag ? busy_r + 1 : 0;
	end
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			low_r <= 0;
		else
			low_r <= trim_req ? 0 : (low_r < 200 ? low_r + 1 : low_r);
	end
	a_busy_oe_off: assert property (trim_busy_flag |-> data_oe_n && output_data_clock_oe_n)
		else $error("outputs enabled during calibration");
	a_output_data_clock_held: assert property (trim_busy_flag && $past(trim_busy_flag) |-> $stable(output_data_clock))
		else $error("data clock moved during calibration");
	a_oe_back: assert property ($fell(trim_busy_flag) && !power_down_pin |-> !data_oe_n && !output_data_clock_oe_n)
		else $error("outputs not back after calibration");
	a_req_start: assert property ($rose(trim_req) && !power_down_pin |-> ##79 !trim_busy_flag ##1 trim_busy_flag)
		else $error("calibration start not 80 cycles after request");
	a_req_low80: assert property ($rose(trim_req) |-> low_r >= 80)
		else $error("request raised before 80 low cycles");
	a_busy_len: assert property ($fell(trim_busy_flag) |-> busy_r == CAL_CYC)
		else $error("calibration length wrong");
	a_busy_max: assert property (trim_busy_flag |-> busy_r < CAL_CYC)
		else $error("calibration overran");
	a_des_off: assert property (trim_busy_flag |-> !des_mode)
		else $error("dual edge mode during calibration");
	a_pd_no_cal: assert property (power_down_pin && !trim_busy_flag |=> !trim_busy_flag)
		else $error("calibration started while powered down");
	a_span_norm: assert property (!ext_mode |=> span_mv == ($past(input_span_select) ? `ADSC_SPAN_HIGH_MV : `ADSC_SPAN_LOW_MV))
		else $error("normal span wrong");
	c_cal: cover property ($rose(trim_busy_flag));
	c_cal_pd: cover property (trim_busy_flag && power_down_pin);
	c_cal_end: cover property ($fell(trim_busy_flag));
endmodule : adsc_cal_monitor
`default_nettype wire

//--- bench/test_adc_self_calibration_control.sv
// Self-checking bench joining the converter and controller ends.
`timescale 1ns/1ns
`default_nettype none
`include "adsc_consts.svh"
module test_adc_self_calibration_control;
	import adsc_pkg::*;
	localparam int unsigned CAL = 10;
	logic       clk, dev_rst_b, hst_rst_b, ce, wr, rd, rd_d, apd, ordy;
	adsc_data_t cdat;
	adsc_addr_t addr;
	adsc_word_t wdat, rdat, e;
	adsc_mv_t   v;
	adsc_word_t exp_q[$];
	int         n_mismatch, checks_done, t0, n;
	adsc_if L();
	adsc_dev #(.SHORT_WAIT_CYC(8), .LONG_WAIT_CYC(16), .CAL_CYC(CAL)) adsc_dev_i (.CLK_SYS(clk),
		.RST_B(dev_rst_b), .CE(ce), .CONV_DATA(cdat), .LINK(L), .ANALOG_PD(apd), .OUT_READY(ordy));
	adsc_host #(.ADVISE_CYC(50)) adsc_host_i (.CLK_SYS(clk), .RST_B(hst_rst_b), .CE(ce), .ADDR(addr),
		.WDATA(wdat), .WR(wr), .RD(rd), .RDATA(rdat), .LINK(L));
	adsc_cal_monitor #(.CAL_CYC(CAL)) adsc_cal_monitor_i (.CLK_SYS(clk), .RST_B(dev_rst_b),
		.trim_req(L.trim_req), .power_down_pin(L.power_down_pin), .input_span_select(L.input_span_select),
		.ext_mode(L.ext_mode), .des_mode(L.des_mode), .trim_busy_flag(L.trim_busy_flag),
		.data_oe_n(L.data_oe_n), .output_data_clock(L.output_data_clock), .output_data_clock_oe_n(L.output_data_clock_oe_n),
		.span_mv(L.span_mv));
	task automatic chk(input string nm, input adsc_word_t ex, input adsc_word_t g);
		checks_done++;
		if (g !== ex)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// Strobes are left high by the access tasks so back-to-back cycles need no gap.
	task automatic cyc(input int k);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wrr(input adsc_addr_t a, input adsc_word_t d);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wrr
	task automatic rdr(input adsc_addr_t a, input adsc_word_t ex);
		exp_q.push_back(ex);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : rdr
	task automatic wpin(input bit s, input logic lv, output int k);
		k = 0;
		while ((s ? L.trim_req : L.trim_busy_flag) !== lv && k < 300)
		begin
			cyc(1);
			k++;
		end
		if (k >= 300)
			chk("pin_wait", 0, 1);
	endtask : wpin
	task automatic boot(input adsc_word_t c, input int hold, output int k);
		wrr(`ADSC_ADDR_CTRL, c);
		dev_rst_b <= 1'b0;
		cyc(8);
		chk("apd_in_reset", 1, apd);
		dev_rst_b <= 1'b1;
		if (hold > 0)
		begin
			cyc(hold);
			chk("pd_hold", 16'h0002, {apd, L.trim_busy_flag});
			wrr(`ADSC_ADDR_CTRL, c & 16'hfffe);
		end
		wpin(0, 1, k);
		wpin(0, 0, n);
		chk("boot_cal_len", CAL, adsc_word_t'(n));
	endtask : boot
	always @(posedge clk)
		rd_d <= rd;
	always @(negedge clk)
		if (rd_d === 1'b1)
			chk("rdata", exp_q.pop_front(), rdat);
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		{dev_rst_b, hst_rst_b, wr, rd, cdat, addr, wdat} = '0;
		ce = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		void'($urandom(55));
		cyc(8);
		hst_rst_b <= 1'b1;
		boot(16'h0000, 0, t0);
		chk("t_short", 1, (t0 >= 7) && (t0 <= 10));
		boot(16'h0002, 0, n);
		chk("t_long", adsc_word_t'(t0 + 8), adsc_word_t'(n));
		boot(16'h000a, 0, n);
		chk("t_ext", adsc_word_t'(t0), adsc_word_t'(n));
		boot(16'h0001, 20, n);
		chk("t_pd", 1, (n + 2 >= t0) && (n <= t0 + 2));
		$display("power-on tests done");
		wrr(`ADSC_ADDR_CTRL, 16'h0010);
		cyc(2);
		chk("des_on", 1, L.des_mode);
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		wpin(1, 1, n);
		wpin(0, 1, n);
		chk("req_latency", 80, adsc_word_t'(n));
		wpin(0, 0, n);
		chk("cal_len", CAL, adsc_word_t'(n));
		chk("ready_early", 0, ordy);
		cyc(5);
		chk("ready_late", 1, ordy);
		rdr(`ADSC_ADDR_STAT, 16'h001c);
		cyc(2);
		chk("des_back", 1, L.des_mode);
		wrr(`ADSC_ADDR_STAT, 16'h0014);
		rdr(`ADSC_ADDR_STAT, 16'h0008);
		rdr(4'hf, 16'h0000);
		$display("on-command test done");
		wrr(`ADSC_ADDR_CTRL, 16'h0000);
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		wpin(1, 1, n);
		wpin(0, 1, n);
		cyc(3);
		wrr(`ADSC_ADDR_CTRL, 16'h0001);
		cyc(2);
		chk("pd_during_cal", 16'h0001, {apd, L.trim_busy_flag});
		wpin(0, 0, n);
		cyc(3);
		chk("pd_after_cal", 1, apd);
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		cyc(200);
		chk("cal_in_pd", 0, L.trim_busy_flag);
		rdr(`ADSC_ADDR_STAT, 16'h001c);
		$display("power-down tests done");
		wrr(`ADSC_ADDR_CTRL, 16'h0000);
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		wpin(1, 1, n);
		// Releasing the converter while the request pin is high must skip the power-on calibration.
		dev_rst_b <= 1'b0;
		cyc(2);
		dev_rst_b <= 1'b1;
		cyc(40);
		chk("skip_cal", 16'h0000, {apd, L.trim_busy_flag});
		hst_rst_b <= 1'b0;
		cyc(2);
		hst_rst_b <= 1'b1;
		wrr(`ADSC_ADDR_CMD, 16'h0001);
		wpin(1, 1, n);
		wpin(0, 1, n);
		chk("cal_after_skip", 80, adsc_word_t'(n));
		wpin(0, 0, n);
		chk("cal_after_skip_len", CAL, adsc_word_t'(n));
		$display("strap skip test done");
		for (int i = 0; i < 8; i++)
		begin
			v = adsc_mv_t'($urandom % 1024);
			cdat <= adsc_data_t'($urandom);
			wrr(`ADSC_ADDR_SPAN, adsc_word_t'(v));
			wrr(`ADSC_ADDR_CTRL, i < 2 ? adsc_word_t'(i << 2) : 16'h0008);
			cyc(3);
			if (i < 2)
				e = i ? `ADSC_SPAN_HIGH_MV : `ADSC_SPAN_LOW_MV;
			else
				e = v < `ADSC_SPAN_MIN_MV ? `ADSC_SPAN_MIN_MV : (v > `ADSC_SPAN_MAX_MV ? `ADSC_SPAN_MAX_MV : v);
			chk("span", e, adsc_word_t'(L.span_mv));
			chk("data_out", adsc_word_t'(cdat), {7'h00, L.data_oe_n, L.data_out});
		end
		$display("span test done");
		cyc(2);
		test_done();
	end
endmodule : test_adc_self_calibration_control
`default_nettype wire
